// ### logic/sfe_pkg.sv
// Shared constants and types of the serial transfer format engine
package sfe_pkg;
  localparam int DW   = 16;
  localparam int NCS  = 4;
  localparam int NSET = 2;
  localparam int BW   = 4;
  localparam int EW   = 6;
  localparam logic [DW-1:0] RST_WORD  = 16'h0000;
  localparam logic [3:0]    TOP_BIT   = 4'hf;
  localparam logic [EW-1:0] EDGE_ONE  = 6'h01;
  localparam logic [EW-1:0] EDGE_TWO  = 6'h02;
  localparam logic [EW-1:0] EDGE_MODS = 6'h03;
  localparam logic [15:0]   CNT_ONE   = 16'h0001;
  localparam logic [15:0]   FREE_GAP_TICKS = 16'h0002;
  localparam logic [1:0]    SMPL_0    = 2'h0;
  localparam logic [1:0]    SMPL_1    = 2'h1;
  localparam logic [1:0]    SMPL_2    = 2'h2;
  localparam logic [1:0]    SMPL_BAD  = 2'h3;
  localparam logic [2:0]    SYNC_RST  = 3'h3;

  typedef struct packed {
    logic [DW-1:0]  data;
    logic [BW-1:0]  bits_m1;
    logic [NCS-1:0] sel;
    logic           keep;
    logic           eoq;
    logic [0:0]     set;
  } sfe_cmd_t;

  typedef struct packed {
    logic       cpol;
    logic       cpha;
    logic [7:0] half;
    logic [7:0] csc;
    logic [7:0] asc;
    logic [15:0] dt;
  } sfe_attr_t;

  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_POL  = 7'h02,
    S_CSC  = 7'h04,
    S_XFER = 7'h08,
    S_LATE = 7'h10,
    S_ASC  = 7'h20,
    S_DT   = 7'h40
  } sfe_state_t;
endpackage

// ### logic/sfe_engine.sv
// Serial transfer format engine: master sequencing and slave response
// Behaviour
// - Classic phase one: drive odd, sample even edges
// - Master asserts select, waits, first edge with data
// - After-clock delay, deselect, then after-transfer delay
// - Phase one flags and counter on last edge
// - Modified phase zero: data at select, odd edges
// - Modified phase zero master drives one cycle later
// - Sample delay field: zero, one, two cycles
// - Modified phase one: master samples odd from third
// - Last bit sampled half period later, no edge without free clock
// - Without keep, selects return to idle levels
// - Keep with same select: stays asserted, no deselect
// - Kept-select gap is after plus select delay
// - Keep with different selects acts as clear, except with free clock
// - Slave clocked with empty queue flags underflow
// - Polarity change one cycle before select asserts
// - Free clock runs always in master mode, phase one only
// - Free clock: no select delays, one-period gap
// - Free clock starts at set zero, then takes each command's set
// - Phase decides data before or on first edge
// - Modified enable picks late sampling formats
`timescale 1ns/100ps
`default_nettype none
module sfe_engine (
  input  wire logic                                 clk_sys_i,
  input  wire logic                                 nrst_i,
  input  wire logic                                 master_mode_i,
  input  wire logic                                 modified_format_enable_i,
  input  wire logic [1:0]                           master_sample_delay_i,
  input  wire logic                                 free_running_clock_enable_i,
  input  wire logic [sfe_pkg::NCS-1:0]              select_idle_levels_i,
  input  wire sfe_pkg::sfe_attr_t [sfe_pkg::NSET-1:0] attr_i,
  input  wire logic                                 cmd_valid_i,
  input  wire sfe_pkg::sfe_cmd_t                    cmd_i,
  input  wire logic                                 slave_clock_i,
  input  wire logic                                 slave_select_n_i,
  input  wire logic                                 serial_data_in_i,
  input  wire logic                                 underflow_clear_i,
  output logic                                      cmd_pop_o,
  output logic                                      serial_clock_o,
  output logic [sfe_pkg::NCS-1:0]                   chip_select_line_o,
  output logic                                      serial_data_out_o,
  output logic                                      frame_done_flag_o,
  output logic                                      end_of_queue_flag_o,
  output logic [sfe_pkg::DW-1:0]                    rx_data_o,
  output logic                                      rx_valid_o,
  output logic [7:0]                                receive_entry_counter_o,
  output logic                                      transmit_underflow_o
);
  import sfe_pkg::*;

  logic [1:0]     rst_sy;
  logic           rst_n;
  logic [2:0]     sy0, sy1, sy2, lv, next_lv;
  sfe_state_t     st, next_st;
  sfe_cmd_t       cmdr, next_cmdr;
  logic [DW-1:0]  tx, next_tx, rx, next_rx, rxd, next_rxd;
  logic [15:0]    cnt, next_cnt;
  logic [7:0]     tk, next_tk, rcnt, next_rcnt;
  logic [EW-1:0]  edge_n, next_edge, e, nedges;
  logic [BW:0]    nrx, next_nrx;
  logic [NCS-1:0] cs, next_cs, act;
  logic [1:0]     smp, next_smp;
  logic [0:0]     cur, next_cur;
  logic sck, next_sck, sdo, next_sdo, pop, next_pop, done, next_done;
  logic eoq, next_eoq, rxv, next_rxv, uf, next_uf, loaded, next_loaded;
  logic drv, next_drv, free_d;
  sfe_attr_t a;
  logic free, mod, cpha, run, tick, fire, trig, smp_now, take, pre;
  logic sedge, ssel, ss_fall, sin;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sy <= 2'h0;
    end else begin
      rst_sy <= {rst_sy[0], 1'b1};
    end
  end
  assign rst_n = rst_sy[1];

  always_comb begin
    free = free_running_clock_enable_i;
    mod = modified_format_enable_i;
    a = master_mode_i ? attr_i[cur] : attr_i[0];
    cpha = master_mode_i ? (a.cpha | free) : a.cpha;
    nedges = {1'b0, cmdr.bits_m1, 1'b0} + EDGE_TWO;
    act = select_idle_levels_i ^ cmdr.sel;
    run = master_mode_i && (free || st == S_XFER);
    tick = run && ((tk + 8'h01) >= a.half);
    next_tk = (!run || tick) ? 8'h00 : tk + 8'h01;
    next_lv = (sy1 & sy2) | (lv & (sy1 ^ sy2));
    sin = lv[2];
    ssel = !lv[1];
    sedge = next_lv[0] ^ lv[0];
    ss_fall = lv[1] & ~next_lv[1];
    next_st = st;
    next_cmdr = cmdr;
    {next_tx, next_rx, next_rxd, next_cnt, next_edge, next_nrx} = {tx, rx, rxd, cnt, edge_n, nrx};
    {next_cs, next_sck, next_sdo, next_rcnt, next_loaded} = {cs, sck, sdo, rcnt, loaded};
    next_cur = (free && !free_d) ? 1'b0 : cur;
    {next_pop, next_done, next_eoq, next_rxv, next_drv} = 5'h00;
    next_uf = uf & ~underflow_clear_i;
    {take, pre, fire, trig} = 4'h0;
    e = edge_n + EDGE_ONE;
    if (master_mode_i) begin
      if (free && tick) begin
        next_sck = ~sck;
      end
      case (st)
        S_IDLE: begin
          if (cmd_valid_i) begin
            take = 1'b1;
            next_st = S_POL;
            if (!free) begin
              next_sck = attr_i[cmd_i.set].cpol;
            end
          end
        end
        S_POL: begin
          if (!free) begin
            next_cs = act;
            pre = 1'b1;
            next_cnt = {8'h00, a.csc};
            next_st = S_CSC;
          end else if (tick && sck != a.cpol) begin
            next_cs = act;
            next_st = S_XFER;
          end
        end
        S_CSC: begin
          if (cnt <= CNT_ONE) begin
            fire = 1'b1;
            next_st = S_XFER;
          end else begin
            next_cnt = cnt - CNT_ONE;
          end
        end
        S_XFER: fire = tick;
        S_LATE: begin
          if (cnt <= CNT_ONE) begin
            trig = 1'b1;
            next_st = free ? S_DT : S_ASC;
            next_cnt = free ? FREE_GAP_TICKS : {8'h00, a.asc};
            if (free && !cmdr.keep) begin
              next_cs = select_idle_levels_i;
            end
          end else begin
            next_cnt = cnt - CNT_ONE;
          end
        end
        S_ASC: begin
          if (cnt > CNT_ONE) begin
            next_cnt = cnt - CNT_ONE;
          end else if (cmd_valid_i && cmdr.keep && cmd_i.sel == cmdr.sel) begin
            take = 1'b1;
            pre = 1'b1;
            next_cnt = {8'h00, a.csc};
            next_st = S_CSC;
          end else begin
            next_cs = select_idle_levels_i;
            next_cnt = a.dt;
            next_st = S_DT;
          end
        end
        S_DT: begin
          if (free) begin
            if (tick && cnt <= CNT_ONE) begin
              next_st = cmd_valid_i ? S_XFER : S_IDLE;
              next_cs = cmd_valid_i ? (select_idle_levels_i ^ cmd_i.sel) : select_idle_levels_i;
              take = cmd_valid_i;
            end else if (tick) begin
              next_cnt = cnt - CNT_ONE;
            end
          end else if (cnt <= CNT_ONE) begin
            next_st = S_IDLE;
          end else begin
            next_cnt = cnt - CNT_ONE;
          end
        end
        default: next_st = S_IDLE;
      endcase
    end else begin
      next_st = S_IDLE;
      next_cs = select_idle_levels_i;
      next_sck = a.cpol;
      if (ss_fall) begin
        next_edge = '0;
        if (!loaded && cmd_valid_i) begin
          take = 1'b1;
          pre = 1'b1;
        end
      end
      if (ssel && sedge) begin
        fire = 1'b1;
        if (!loaded) begin
          next_uf = 1'b1;
        end
      end
    end
    if (fire) begin
      next_edge = e;
      if (master_mode_i && !free) begin
        next_sck = ~sck;
      end
      if (cpha) begin
        if (e[0]) begin
          next_sdo = tx[DW-1];
          next_tx = tx << 1;
          trig = master_mode_i && mod && e >= EDGE_MODS;
        end else begin
          trig = !(master_mode_i && mod);
        end
      end else if (e[0]) begin
        trig = 1'b1;
        if (mod && master_mode_i) begin
          next_drv = 1'b1;
        end else if (mod) begin
          next_sdo = tx[DW-1];
          next_tx = tx << 1;
        end
      end else if (!mod) begin
        next_sdo = tx[DW-1];
        next_tx = tx << 1;
      end
      if (e == nedges) begin
        next_done = 1'b1;
        next_eoq = master_mode_i & cmdr.eoq;
        next_rcnt = rcnt + 8'h01;
        // Master frames must not leave an entry marked as loaded for slave use
        next_loaded = 1'b0;
        if (!master_mode_i) begin
          next_edge = '0;
          take = cmd_valid_i;
          pre = cmd_valid_i;
        end else if (mod && cpha) begin
          next_st = S_LATE;
          next_cnt = {8'h00, a.half};
        end else if (free) begin
          next_st = S_DT;
          next_cnt = FREE_GAP_TICKS;
          if (!cmdr.keep) begin
            next_cs = select_idle_levels_i;
          end
        end else begin
          next_st = S_ASC;
          next_cnt = {8'h00, a.asc};
        end
      end
    end
    if (drv) begin
      next_sdo = tx[DW-1];
      next_tx = tx << 1;
    end
    smp_now = (trig && (!master_mode_i || !mod || master_sample_delay_i == SMPL_0
              || master_sample_delay_i == SMPL_BAD)) || (smp[0] && master_sample_delay_i == SMPL_1)
              || smp[1];
    next_smp = {smp[0] && master_sample_delay_i == SMPL_2,
                trig && master_mode_i && mod && (master_sample_delay_i == SMPL_1
                || master_sample_delay_i == SMPL_2)};
    if (smp_now) begin
      next_rx = {rx[DW-2:0], sin};
      next_nrx = nrx + 5'h01;
      if (next_nrx == {1'b0, cmdr.bits_m1} + 5'h01) begin
        next_rxd = next_rx;
        next_rxv = 1'b1;
        next_nrx = 5'h00;
      end
    end
    if (take) begin
      next_cmdr = cmd_i;
      next_tx = cmd_i.data << (TOP_BIT - cmd_i.bits_m1);
      next_pop = 1'b1;
      next_loaded = 1'b1;
      next_nrx = 5'h00;
      next_edge = '0;
      if (master_mode_i) begin
        next_cur = cmd_i.set;
      end
    end
    if (pre && !cpha) begin
      next_sdo = next_tx[DW-1];
      next_tx = next_tx << 1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      {sy0, sy1, sy2, lv} <= {4{SYNC_RST}};
      st <= S_IDLE;
      cmdr <= '0;
      {tx, rx, rxd} <= {3{RST_WORD}};
      {cnt, tk, rcnt, edge_n, nrx, smp, cur} <= '0;
      cs <= '0;
      {sck, sdo, pop, done, eoq, rxv, uf, loaded, drv, free_d} <= '0;
    end else begin
      sy0 <= {serial_data_in_i, slave_select_n_i, slave_clock_i};
      sy1 <= sy0;
      sy2 <= sy1;
      lv <= next_lv;
      st <= next_st;
      cmdr <= next_cmdr;
      {tx, rx, rxd} <= {next_tx, next_rx, next_rxd};
      {cnt, tk, rcnt, edge_n, nrx, smp, cur} <= {next_cnt, next_tk, next_rcnt, next_edge, next_nrx, next_smp, next_cur};
      cs <= next_cs;
      {sck, sdo, pop, done, eoq, rxv, uf, loaded, drv, free_d} <=
        {next_sck, next_sdo, next_pop, next_done, next_eoq, next_rxv, next_uf, next_loaded, next_drv, free};
    end
  end

  assign {cmd_pop_o, serial_clock_o, chip_select_line_o, serial_data_out_o} = {pop, sck, cs, sdo};
  assign {frame_done_flag_o, end_of_queue_flag_o, rx_data_o, rx_valid_o} = {done, eoq, rxd, rxv};
  assign {receive_entry_counter_o, transmit_underflow_o} = {rcnt, uf};

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n);

  property p_first_edge; st == S_CSC && cnt <= CNT_ONE |=> edge_n == EDGE_ONE && sck != $past(sck); endproperty
  a_first_edge: assert property (p_first_edge) else $error("no first edge after select delay");
  property p_done_last; done && master_mode_i |-> edge_n == nedges; endproperty
  a_done_last: assert property (p_done_last) else $error("done flag not on last edge");
  property p_keep; $past(st) == S_ASC && st == S_CSC |-> $stable(cs); endproperty
  a_keep: assert property (p_keep) else $error("kept select changed between frames");
  property p_idle_gap; st == S_DT && !free |-> cs == select_idle_levels_i; endproperty
  a_idle_gap: assert property (p_idle_gap) else $error("select not idle in gap");
  property p_late; st == S_LATE |=> $stable(sck); endproperty
  a_late: assert property (p_late) else $error("clock edge during late sample");
  property p_pol; st == S_POL && !free |-> sck == a.cpol ##1 $stable(sck) && st == S_CSC; endproperty
  a_pol: assert property (p_pol) else $error("polarity not settled before select");
  property p_underflow; !master_mode_i && ssel && sedge && !loaded |=> uf; endproperty
  a_underflow: assert property (p_underflow) else $error("underflow not flagged");
  property p_smp2;
    trig && master_mode_i && mod && master_sample_delay_i == SMPL_2 |-> !smp_now ##1 !smp_now ##1 smp_now;
  endproperty
  a_smp2: assert property (p_smp2) else $error("sample delay two wrong");
  property p_mod_drive;
    fire && master_mode_i && mod && !cpha && !edge_n[0] |=> drv ##1 sdo == $past(tx[DW-1]);
  endproperty
  a_mod_drive: assert property (p_mod_drive) else $error("late drive missing");
  property p_free_nodelay; free && master_mode_i |-> st != S_CSC && st != S_ASC; endproperty
  a_free_nodelay: assert property (p_free_nodelay) else $error("select delay in free clock mode");
  c_keep: cover property ($past(st) == S_ASC && st == S_CSC);
  c_late: cover property (st == S_LATE ##1 st == S_ASC);
  c_uf: cover property ($rose(uf));
  c_free: cover property (free && done);
endmodule
`default_nettype wire

// ### tb/sfe_peer.sv
// Behavioural serial peripheral for the engine's master side
`timescale 1ns/100ps
`default_nettype none
module sfe_peer (
  input  wire logic       clk_sys_i,
  input  wire logic       serial_clock_i,
  input  wire logic       selected_i,
  input  wire logic       serial_data_i,
  input  wire logic [7:0] reply_i,
  output logic            serial_data_o,
  output logic [7:0]      got_o
);
  logic       sck_q;
  logic [4:0] n_edge;

  initial begin
    serial_data_o = 1'b0;
    got_o = 8'h00;
    sck_q = 1'b0;
    n_edge = 5'h00;
  end

  always @(posedge clk_sys_i) begin
    sck_q <= serial_clock_i;
    if (!selected_i) begin
      n_edge <= 5'h00;
      // Released line toggles so no stale level looks valid
      serial_data_o <= ~serial_data_o;
    end else if (serial_clock_i != sck_q) begin
      n_edge <= n_edge + 5'h01;
      if (!n_edge[0])
        serial_data_o <= reply_i[3'h7 - n_edge[3:1]];
      else
        got_o <= {got_o[6:0], serial_data_i};
    end
  end
endmodule
`default_nettype wire

// ### tb/sfe_engine_test.sv
// Self-checking bench of the serial transfer format engine
`timescale 1ns/100ps
`default_nettype none
module sfe_engine_test;
  import sfe_pkg::*;
  logic clk_sys_i, nrst_i, mst, mod_en, slv_clk, slv_sel_n, uf_clr, cmd_valid, peer_sdo;
  logic [1:0] smpl;
  sfe_attr_t [NSET-1:0] attr;
  sfe_cmd_t cmd;
  logic cmd_pop, sck, sdo, done, eoq, rx_valid, underflow, sck_q, sck_at_sel;
  logic [NCS-1:0] cs, cs_q;
  logic [DW-1:0] rx_data, rx_q;
  logic [7:0] rx_cnt, exp_cnt, peer_got;
  int n_errors, n_compared, n_done, n_eoq, n_desel, n_edge;
  localparam logic [3:0] IDLE = 4'hf;
  localparam logic [7:0] REPLY = 8'h3c;

  sfe_engine dut (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .master_mode_i(mst), .modified_format_enable_i(mod_en),
    .master_sample_delay_i(smpl), .free_running_clock_enable_i(1'b0), .select_idle_levels_i(IDLE),
    .attr_i(attr), .cmd_valid_i(cmd_valid), .cmd_i(cmd), .slave_clock_i(slv_clk),
    .slave_select_n_i(slv_sel_n), .serial_data_in_i(peer_sdo), .underflow_clear_i(uf_clr),
    .cmd_pop_o(cmd_pop), .serial_clock_o(sck), .chip_select_line_o(cs), .serial_data_out_o(sdo),
    .frame_done_flag_o(done), .end_of_queue_flag_o(eoq), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .receive_entry_counter_o(rx_cnt), .transmit_underflow_o(underflow));

  sfe_peer peer (
    .clk_sys_i(clk_sys_i), .serial_clock_i(sck), .selected_i(cs[1:0] != IDLE[1:0]),
    .serial_data_i(sdo), .reply_i(REPLY), .serial_data_o(peer_sdo), .got_o(peer_got));

  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // Event counters seen on the pins, pre-edge values
  always @(posedge clk_sys_i) begin
    sck_q <= sck;
    cs_q <= cs;
    if (done) n_done++;
    if (eoq) n_eoq++;
    if (cs_q != IDLE && cs == IDLE) n_desel++;
    if (cs_q == IDLE && cs != IDLE) sck_at_sel <= sck;
    if (sck != sck_q && cs != IDLE) n_edge++;
    if (rx_valid) rx_q <= rx_data;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic clear;
    n_done = 0;
    n_eoq = 0;
    n_desel = 0;
    n_edge = 0;
  endtask

  task automatic send(input logic [7:0] d, input logic [3:0] sel, input logic keep, input logic last,
                      input logic set);
    int i;
    cmd = '{data: {8'h00, d}, bits_m1: 4'h7, sel: sel, keep: keep, eoq: last, set: set};
    cmd_valid = 1'b1;
    for (i = 0; i < 3000 && cmd_pop !== 1'b1; i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    if (cmd_pop !== 1'b1) begin
      chk("pop_timeout", 16'h0001, {15'h0000, cmd_pop});
      wrap_up();
    end
    @(posedge clk_sys_i);
    #1;
    cmd_valid = 1'b0;
    exp_cnt = exp_cnt + 8'h01;
  endtask

  // Waits until frames and deselections reach their targets
  task automatic settle(input int frames, input int desels);
    int i;
    for (i = 0; i < 4000 && (n_done < frames || n_desel < desels); i++) begin
      @(posedge clk_sys_i);
      #1;
    end
    if (i == 4000) begin
      chk("settle_timeout", 16'h0000, 16'h0001);
      wrap_up();
    end
    repeat (4) @(posedge clk_sys_i);
    #1;
  endtask

  initial begin
    nrst_i = 1'b0;
    mst = 1'b1;
    mod_en = 1'b0;
    smpl = SMPL_0;
    slv_clk = 1'b0;
    slv_sel_n = 1'b1;
    uf_clr = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    exp_cnt = 8'h00;
    n_errors = 0;
    n_compared = 0;
    attr[0] = '{cpol: 1'b0, cpha: 1'b1, half: 8'h08, csc: 8'h04, asc: 8'h08, dt: 16'h0006};
    attr[1] = '{cpol: 1'b1, cpha: 1'b1, half: 8'h08, csc: 8'h04, asc: 8'h08, dt: 16'h0006};
    clear();
    repeat (4) @(posedge clk_sys_i);
    #1;
    nrst_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1;
    // Single frame: classic, modified, modified with two-cycle sample delay
    for (int m = 0; m < 3; m++) begin
      mod_en = (m != 0);
      smpl = (m == 2) ? SMPL_2 : SMPL_0;
      clear();
      send(8'ha5, 4'h1, 1'b0, 1'b1, 1'b0);
      settle(1, 1);
      chk("edges", 16'd16, n_edge[15:0]);
      chk("peer_got", 16'h00a5, {8'h00, peer_got});
      chk("rx_word", {8'h00, REPLY}, {8'h00, rx_q[7:0]});
      chk("eoq", 16'd1, n_eoq[15:0]);
      chk("frames", 16'd1, n_done[15:0]);
      chk("rx_cnt", {8'h00, exp_cnt}, {8'h00, rx_cnt});
      chk("cs_idle", {12'h000, IDLE}, {12'h000, cs});
    end
    mod_en = 1'b0;
    smpl = SMPL_0;
    // Kept select on the same line: one deselect for two frames
    clear();
    send(8'h5a, 4'h1, 1'b1, 1'b0, 1'b0);
    send(8'hc3, 4'h1, 1'b0, 1'b1, 1'b0);
    settle(2, 1);
    chk("kept_desel", 16'd1, n_desel[15:0]);
    chk("kept_edges", 16'd32, n_edge[15:0]);
    chk("kept_got", 16'h00c3, {8'h00, peer_got});
    chk("kept_cnt", {8'h00, exp_cnt}, {8'h00, rx_cnt});
    // Kept select but another line: returns to idle between
    clear();
    send(8'h11, 4'h1, 1'b1, 1'b0, 1'b0);
    send(8'h22, 4'h2, 1'b0, 1'b1, 1'b0);
    settle(2, 2);
    chk("switch_desel", 16'd2, n_desel[15:0]);
    // Polarity change: clock idle level moves before select asserts
    clear();
    send(8'h96, 4'h1, 1'b0, 1'b1, 1'b1);
    settle(1, 1);
    chk("sck_at_sel", 16'h0001, {15'h0000, sck_at_sel});
    chk("pol_got", 16'h0096, {8'h00, peer_got});
    chk("pol_rx", {8'h00, REPLY}, {8'h00, rx_q[7:0]});
    // Slave clocked with an empty queue
    mst = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1;
    slv_sel_n = 1'b0;
    repeat (4) begin
      #80 slv_clk = ~slv_clk;
    end
    repeat (10) @(posedge clk_sys_i);
    #1;
    chk("underflow", 16'h0001, {15'h0000, underflow});
    slv_sel_n = 1'b1;
    uf_clr = 1'b1;
    @(posedge clk_sys_i);
    #1;
    uf_clr = 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("underflow_clr", 16'h0000, {15'h0000, underflow});
    wrap_up();
  end
endmodule
`default_nettype wire
